// ### hdl/pdwc_cycle_cnt.sv
`timescale 1ns/1ns
module pdwc_cycle_cnt #(
  parameter int W = 6
) (
  input wire logic core_clk_i,
  input wire logic rst_i,
  input wire logic load_i,
  input wire logic [W-1:0] load_val_i,
  input wire logic step_i,
  output logic done_o
);

  logic [W-1:0] cnt_reg;
  logic [W-1:0] cnt_next;
  logic done_reg;
  logic done_next;

  // load wins over a step; count halts at zero
  always_comb begin
    cnt_next = cnt_reg;
    if (load_i) begin
      cnt_next = load_val_i;
    end else if (step_i && (cnt_reg != '0)) begin
      cnt_next = cnt_reg - W'(1);
    end
    done_next = (cnt_next == '0);
  end

  // reset to zero, so done reads high until the first load
  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      cnt_reg <= '0;
      done_reg <= 1'b1;
    end else begin
      cnt_reg <= cnt_next;
      done_reg <= done_next;
    end
  end

  assign done_o = done_reg;

endmodule

// ### hdl/pdwc_pkg.sv
package pdwc_pkg;

  // ==========================================================
  // register map on the special function register port
  localparam logic [7:0] PDWC_PWRCTL_ADDR = 8'h87;
  localparam logic [7:0] PDWC_CKCTRL_ADDR = 8'hB6;

  // ==========================================================
  // field positions and masks
  localparam int PDWC_IDLE_BIT = 0;
  localparam int PDWC_STOP_BIT = 1;
  localparam int PDWC_CLK_HALT_BIT = 1;
  // writable bits: baud doubler, two flags, stop, idle; 6..4 read zero
  localparam logic [7:0] PDWC_PWRCTL_WMASK = 8'h8F;
  // only the clock-halt bit exists; bit 0 reads zero
  localparam logic [7:0] PDWC_CKCTRL_WMASK = 8'h02;
  localparam logic [7:0] PDWC_PWRCTL_RESET = 8'h00;
  localparam logic [7:0] PDWC_CKCTRL_RESET = 8'h00;

  // ==========================================================
  // startup counts: slow oscillator ticks, then crystal cycles
  localparam int PDWC_POR_SLOW_CYC = 14;
  localparam int PDWC_WDOG_SLOW_CYC = 12;
  localparam int PDWC_RESET_XTAL_CYC = 24;
  localparam int PDWC_PIN_WAKE_SLOW_CYC = 3;
  localparam int PDWC_RTC_WAKE_SLOW_CYC = 3;
  localparam int PDWC_WAKE_XTAL_CYC = 52;

  // wake sources: two pins and the real-time clock
  localparam int PDWC_NUM_SRC = 3;
  localparam int PDWC_RTC_SRC = 2;

  // ==========================================================
  // sequencer states
  typedef enum logic [3:0] {
    PDWC_BOOT,
    PDWC_RST_SLOW,
    PDWC_RST_XTAL,
    PDWC_RUN,
    PDWC_IDLE,
    PDWC_STOP,
    PDWC_PD_ENTER,
    PDWC_PD,
    PDWC_WAKE_SLOW,
    PDWC_WAKE_XTAL
  } pdwc_state_t;

endpackage

// ### hdl/pdwc_power_ctrl.sv
// Notes on behaviour
// - setting stop bit enters stop after instruction
// - only watchdog reset leaves stop mode
// - clock-halt bit enters power-down after instruction
// - power-down suspends CPU, keeps all contents
// - power-down shuts clock and regulators in order
// - wake only by enabled pin, RTC, watchdog
// - valid wakeup clears clock-halt bit in hardware
// - wake interrupt served once clocks are restored
// - watchdog in power-down runs full reset sequence
// - wake and interrupt per pin exclusive
// - interrupt detect off in power-down, wake off otherwise
// - pin wake also captured as pending interrupt
// - reset startup: slow ticks then 24 crystal
// - wake startup: 3 slow ticks then 52 crystal
// - idle keeps CPU clock running internally
`timescale 1ns/1ns
module pdwc_power_ctrl
  import pdwc_pkg::*;
#(
  parameter int SLOW_W = 4,
  parameter int XTAL_W = 6
) (
  input wire logic core_clk_i,
  input wire logic rst_i,
  input wire logic [7:0] sfr_addr_i,
  input wire logic sfr_wr_i,
  input wire logic [7:0] sfr_wdata_i,
  input wire logic sfr_rd_i,
  output logic [7:0] sfr_rdata_o,
  input wire logic instr_done_i,
  input wire logic irq_pending_i,
  input wire logic wdog_rst_i,
  input wire logic rtc_wake_i,
  input wire logic [1:0] ext_wake_pin_b_i,
  input wire logic [1:0] port0_alt_function_i,
  input wire logic low_power_oscillator_i,
  input wire logic [PDWC_NUM_SRC-1:0] wake_irq_ack_i,
  output logic [PDWC_NUM_SRC-1:0] wake_irq_o,
  output logic cpu_halt_o,
  output logic cpu_clk_en_o,
  output logic sys_clk_en_o,
  output logic regulator_en_o,
  output logic cpu_rst_o,
  output logic int_detect_en_o,
  output logic wake_detect_en_o
);

  // ==========================================================
  // elaboration checks
  if (((1 << SLOW_W) - 1) < PDWC_POR_SLOW_CYC) begin : g_slow_chk
    $error("SLOW_W too narrow for the reset tick count");
  end
  if (((1 << XTAL_W) - 1) < PDWC_WAKE_XTAL_CYC) begin : g_xtal_chk
    $error("XTAL_W too narrow for the wake crystal count");
  end

  // ==========================================================
  // state
  pdwc_state_t state_reg, state_next;
  logic [7:0] power_control_reg, power_control_next;
  logic [7:0] ckctrl_reg, ckctrl_next;
  logic [7:0] rdata_reg, rdata_next;
  logic [PDWC_NUM_SRC-1:0] pend_reg, pend_next;
  logic [PDWC_NUM_SRC-1:0] irq_reg, irq_next;
  logic [5:0] out_reg, out_next;
  logic wake_det_reg, wake_det_next;
  logic lp_prev_reg;
  logic lp_tick;
  logic [PDWC_NUM_SRC-1:0] wake_src;
  logic slow_load, slow_done, xtal_load, xtal_done;
  logic [SLOW_W-1:0] slow_val;
  logic [XTAL_W-1:0] xtal_val;

  // slow oscillator rising edge, sampled directly, makes a one-cycle tick
  assign lp_tick = low_power_oscillator_i && !lp_prev_reg;

  // gated wake sources
  // a pin wakes only while its alternate function is enabled
  assign wake_src = {rtc_wake_i, ~ext_wake_pin_b_i & port0_alt_function_i};

  // two counters
  // slow ticks are counted first, the crystal count releases the cpu
  pdwc_cycle_cnt #(.W(SLOW_W)) u_slow_cnt (
    .core_clk_i(core_clk_i),
    .rst_i(rst_i),
    .load_i(slow_load),
    .load_val_i(slow_val),
    .step_i(lp_tick),
    .done_o(slow_done)
  );

  pdwc_cycle_cnt #(.W(XTAL_W)) u_xtal_cnt (
    .core_clk_i(core_clk_i),
    .rst_i(rst_i),
    .load_i(xtal_load),
    .load_val_i(xtal_val),
    .step_i(1'b1),
    .done_o(xtal_done)
  );

  // ==========================================================
  // sequencer and register next values
  always_comb begin
    state_next = state_reg;
    power_control_next = power_control_reg;
    ckctrl_next = ckctrl_reg;
    pend_next = pend_reg & ~wake_irq_ack_i;
    slow_load = 1'b0;
    slow_val = '0;
    xtal_load = 1'b0;
    xtal_val = '0;
    rdata_next = rdata_reg;
    if (sfr_rd_i) begin
      unique case (sfr_addr_i)
        PDWC_PWRCTL_ADDR: rdata_next = power_control_reg;
        PDWC_CKCTRL_ADDR: rdata_next = ckctrl_reg;
        default: rdata_next = 8'h00;
      endcase
    end
    // cpu writes land only while it is executing
    if (sfr_wr_i && (state_reg == PDWC_RUN)) begin
      if (sfr_addr_i == PDWC_PWRCTL_ADDR) begin
        power_control_next = sfr_wdata_i & PDWC_PWRCTL_WMASK;
      end
      if (sfr_addr_i == PDWC_CKCTRL_ADDR) begin
        ckctrl_next = sfr_wdata_i & PDWC_CKCTRL_WMASK;
      end
    end
    unique case (state_reg)
      PDWC_BOOT: begin
        slow_load = 1'b1;
        slow_val = SLOW_W'(PDWC_POR_SLOW_CYC);
        state_next = PDWC_RST_SLOW;
      end
      PDWC_RST_SLOW: begin
        if (slow_done) begin
          xtal_load = 1'b1;
          xtal_val = XTAL_W'(PDWC_RESET_XTAL_CYC - 1);
          state_next = PDWC_RST_XTAL;
        end
      end
      PDWC_RST_XTAL: begin
        if (xtal_done) begin
          state_next = PDWC_RUN;
        end
      end
      PDWC_RUN: begin
        // power-down, stop and idle entry
        // power-down is checked first: it saves far more than stop
        if (instr_done_i && ckctrl_reg[PDWC_CLK_HALT_BIT]) begin
          state_next = PDWC_PD_ENTER;
        end else if (instr_done_i && power_control_reg[PDWC_STOP_BIT]) begin
          state_next = PDWC_STOP;
        end else if (instr_done_i && power_control_reg[PDWC_IDLE_BIT]) begin
          state_next = PDWC_IDLE;
        end
      end
      PDWC_IDLE: begin
        // an enabled interrupt ends idle and the hardware clears the bit
        if (irq_pending_i) begin
          power_control_next[PDWC_IDLE_BIT] = 1'b0;
          state_next = PDWC_RUN;
        end
      end
      // stop exit
      // stop ignores interrupts; only the watchdog branch below leaves it
      PDWC_STOP: state_next = PDWC_STOP;
      PDWC_PD_ENTER: state_next = PDWC_PD;
      PDWC_PD: begin
        if (wake_src != '0) begin
          ckctrl_next[PDWC_CLK_HALT_BIT] = 1'b0;
          slow_load = 1'b1;
          slow_val = (wake_src[1:0] != 2'b00) ? SLOW_W'(PDWC_PIN_WAKE_SLOW_CYC) :
                                                SLOW_W'(PDWC_RTC_WAKE_SLOW_CYC);
          state_next = PDWC_WAKE_SLOW;
        end
      end
      PDWC_WAKE_SLOW: begin
        if (slow_done) begin
          xtal_load = 1'b1;
          xtal_val = XTAL_W'(PDWC_WAKE_XTAL_CYC - 1);
          state_next = PDWC_WAKE_XTAL;
        end
      end
      PDWC_WAKE_XTAL: begin
        if (xtal_done) begin
          state_next = PDWC_RUN;
        end
      end
      default: state_next = PDWC_BOOT;
    endcase
    // capture wake as interrupt
    // set wins over an acknowledge in the same cycle
    if (state_reg == PDWC_PD) begin
      pend_next = pend_next | wake_src;
    end
    // watchdog reset
    // watchdog overrides every state and clears the mode registers
    if (wdog_rst_i) begin
      power_control_next = PDWC_PWRCTL_RESET;
      ckctrl_next = PDWC_CKCTRL_RESET;
      pend_next = '0;
      slow_load = 1'b1;
      slow_val = SLOW_W'(PDWC_WDOG_SLOW_CYC);
      xtal_load = 1'b0;
      state_next = PDWC_RST_SLOW;
    end
    irq_next = (state_next == PDWC_RUN) ? pend_next : '0;
  end

  // output decode
  // outputs follow the next state so that each is a plain flip-flop
  always_comb begin
    out_next = '0;
    wake_det_next = (state_next == PDWC_PD);
    unique case (state_next)
      PDWC_BOOT, PDWC_RST_SLOW: out_next = 6'b1_0_0_1_0_1;
      PDWC_RST_XTAL: out_next = 6'b1_0_1_1_0_1;
      PDWC_RUN: out_next = 6'b0_1_1_1_1_0;
      PDWC_IDLE, PDWC_STOP: out_next = 6'b1_1_1_1_1_0;
      PDWC_PD_ENTER: out_next = 6'b1_0_1_1_0_0;
      PDWC_PD: out_next = 6'b1_0_0_0_0_0;
      PDWC_WAKE_SLOW: out_next = 6'b1_0_0_1_0_0;
      PDWC_WAKE_XTAL: out_next = 6'b1_0_1_1_0_0;
      default: out_next = 6'b1_0_0_1_0_1;
    endcase
  end

  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      state_reg <= PDWC_BOOT;
      power_control_reg <= PDWC_PWRCTL_RESET;
      ckctrl_reg <= PDWC_CKCTRL_RESET;
      rdata_reg <= 8'h00;
      pend_reg <= '0;
      irq_reg <= '0;
      out_reg <= 6'b1_0_0_1_0_1;
      wake_det_reg <= 1'b0;
      lp_prev_reg <= 1'b0;
    end else begin
      state_reg <= state_next;
      power_control_reg <= power_control_next;
      ckctrl_reg <= ckctrl_next;
      rdata_reg <= rdata_next;
      pend_reg <= pend_next;
      irq_reg <= irq_next;
      out_reg <= out_next;
      wake_det_reg <= wake_det_next;
      lp_prev_reg <= low_power_oscillator_i;
    end
  end

  // field order: halt, cpu clk, sys clk, regulator, int detect, cpu reset
  assign cpu_halt_o = out_reg[5];
  assign cpu_clk_en_o = out_reg[4];
  assign sys_clk_en_o = out_reg[3];
  assign regulator_en_o = out_reg[2];
  assign int_detect_en_o = out_reg[1];
  assign cpu_rst_o = out_reg[0];
  assign wake_detect_en_o = wake_det_reg;
  assign wake_irq_o = irq_reg;
  assign sfr_rdata_o = rdata_reg;

  // ==========================================================
  // checks
  default clocking cb @(posedge core_clk_i); endclocking
  default disable iff (rst_i);

  logic [7:0] xtal_cyc_reg;
  logic [3:0] tick_cyc_reg;
  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      xtal_cyc_reg <= 8'h00;
      tick_cyc_reg <= 4'h0;
    end else begin
      xtal_cyc_reg <= (state_next == state_reg) ? xtal_cyc_reg + 8'h01 : 8'h01;
      tick_cyc_reg <= (state_next != state_reg) ? 4'h0 :
                      tick_cyc_reg + {3'b000, lp_tick};
    end
  end

  sequence pd_request_s;
    state_reg == PDWC_RUN && ckctrl_reg[PDWC_CLK_HALT_BIT] && instr_done_i && !wdog_rst_i;
  endsequence
  sequence shutdown_s;
    (!cpu_clk_en_o && sys_clk_en_o) ##1 (!sys_clk_en_o && !regulator_en_o);
  endsequence

  stop_entry_a: assert property (
    state_reg == PDWC_RUN && instr_done_i && power_control_reg[PDWC_STOP_BIT] &&
    !ckctrl_reg[PDWC_CLK_HALT_BIT] && !wdog_rst_i |=> state_reg == PDWC_STOP && cpu_halt_o)
    else $error("stop mode not entered");
  stop_hold_a: assert property (
    state_reg == PDWC_STOP && !wdog_rst_i |=> state_reg == PDWC_STOP)
    else $error("stop mode left without watchdog");
  pd_shutdown_a: assert property (
    pd_request_s ##1 !wdog_rst_i |-> shutdown_s)
    else $error("power-down shutdown order wrong");
  wake_clear_a: assert property (
    state_reg == PDWC_PD && wake_src != '0 && !wdog_rst_i |=>
    !ckctrl_reg[PDWC_CLK_HALT_BIT] && state_reg == PDWC_WAKE_SLOW)
    else $error("wakeup did not clear halt bit");
  wdog_reset_a: assert property (
    wdog_rst_i |=> cpu_rst_o && state_reg == PDWC_RST_SLOW && ckctrl_reg == PDWC_CKCTRL_RESET)
    else $error("watchdog did not start reset");
  pend_source_a: assert property (
    $rose(pend_reg[0]) || $rose(pend_reg[1]) |-> $past(state_reg) == PDWC_PD)
    else $error("wake captured outside power-down");
  irq_deliver_a: assert property (
    wake_irq_o == ((state_reg == PDWC_RUN) ? pend_reg : '0))
    else $error("wake interrupt delivery mismatch");
  wake_capture_a: assert property (
    state_reg == PDWC_PD && !wdog_rst_i |=> (pend_reg & $past(wake_src)) == $past(wake_src))
    else $error("wake event not captured as interrupt");
  xtal_wake_a: assert property (
    state_reg == PDWC_WAKE_XTAL && state_next != PDWC_WAKE_XTAL && !wdog_rst_i |->
    xtal_cyc_reg == 8'(PDWC_WAKE_XTAL_CYC))
    else $error("wake crystal count wrong");
  xtal_reset_a: assert property (
    state_reg == PDWC_RST_XTAL && state_next == PDWC_RUN |->
    xtal_cyc_reg == 8'(PDWC_RESET_XTAL_CYC))
    else $error("reset crystal count wrong");
  slow_wake_a: assert property (
    state_reg == PDWC_WAKE_SLOW && state_next == PDWC_WAKE_XTAL |->
    tick_cyc_reg + {3'b000, lp_tick} == 4'(PDWC_PIN_WAKE_SLOW_CYC))
    else $error("wake slow tick count wrong");
  idle_clock_a: assert property (
    state_reg == PDWC_IDLE |-> cpu_clk_en_o && cpu_halt_o)
    else $error("idle stopped the cpu clock");

endmodule

// ### sim/pdwc_far_model.sv
`timescale 1ns/1ns
// ==========================================================
// far side: pulled-up wake pins and the slow oscillator
module pdwc_far_model #(
  parameter int SLOW_HALF_NS = 430
) (
  input wire logic [1:0] pull_low_i,
  output logic [1:0] pin_b_o,
  output logic slow_osc_o
);
  // wake use only
  // pins serve wakeup alone here; a released pin floats back high
  assign pin_b_o = ~pull_low_i;
  // free-running, phase unrelated to the core clock on purpose
  initial begin
    slow_osc_o = 1'b0;
    forever #(SLOW_HALF_NS) slow_osc_o = ~slow_osc_o;
  end
endmodule

// ### sim/tb.sv
`timescale 1ns/1ns
module tb;
  import pdwc_pkg::*;
  // ==========================================================
  // signals; slow period lies between 8 and 9 core cycles
  localparam int SP_LO = 8;
  localparam int SP_HI = 9;
  logic core_clk_i, rst_i, sfr_wr_i, sfr_rd_i, irq_pending_i, rtc_wake_i, slow_osc;
  logic [1:0] evt, pins_b, alt_en, pull_low;
  logic [7:0] sfr_addr_i, sfr_wdata_i, sfr_rdata_o, rd;
  logic [PDWC_NUM_SRC-1:0] ack, wake_irq;
  logic cpu_halt, cpu_clk_en, sys_clk_en, reg_en, cpu_rst, int_det, wake_det;
  int failures, checks_done, seed, exp_pwrctl, exp_ck, cyc, n;
  int irq_q[$];

  pdwc_power_ctrl u_dut (
    .core_clk_i(core_clk_i), .rst_i(rst_i), .sfr_addr_i(sfr_addr_i),
    .sfr_wr_i(sfr_wr_i), .sfr_wdata_i(sfr_wdata_i), .sfr_rd_i(sfr_rd_i),
    .sfr_rdata_o(sfr_rdata_o), .instr_done_i(evt[0]), .irq_pending_i(irq_pending_i),
    .wdog_rst_i(evt[1]), .rtc_wake_i(rtc_wake_i), .ext_wake_pin_b_i(pins_b),
    .port0_alt_function_i(alt_en), .low_power_oscillator_i(slow_osc),
    .wake_irq_ack_i(ack), .wake_irq_o(wake_irq), .cpu_halt_o(cpu_halt),
    .cpu_clk_en_o(cpu_clk_en), .sys_clk_en_o(sys_clk_en), .regulator_en_o(reg_en),
    .cpu_rst_o(cpu_rst), .int_detect_en_o(int_det), .wake_detect_en_o(wake_det)
  );
  pdwc_far_model u_far (.pull_low_i(pull_low), .pin_b_o(pins_b), .slow_osc_o(slow_osc));

  // ==========================================================
  // clock and hang guard
  initial begin
    core_clk_i = 1'b0;
    forever #50 core_clk_i = ~core_clk_i;
  end
  initial begin
    #5000000;
    failures++;
    stop_test();
  end

  // ==========================================================
  // shared tasks
  task automatic chk(input string nm, input logic [7:0] seen, input logic [7:0] exp);
    checks_done++;
    if (seen !== exp) begin
      failures++;
      $display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  // a cycle window is folded into the common check as a pass bit
  task automatic rng(input string nm, input int v, input int lo, input int hi);
    chk(nm, 8'(v >= lo && v <= hi), 8'h01);
  endtask
  task automatic stop_test();
    $display("checks %0d failures %0d", checks_done, failures);
    if (failures == 0 && checks_done > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask
  task automatic sfr_write(input logic [7:0] a, input logic [7:0] d);
    @(posedge core_clk_i);
    sfr_addr_i <= a;
    sfr_wdata_i <= d;
    sfr_wr_i <= 1'b1;
    @(posedge core_clk_i);
    sfr_wr_i <= 1'b0;
  endtask
  task automatic sfr_read(input logic [7:0] a, output logic [7:0] d);
    @(posedge core_clk_i);
    sfr_addr_i <= a;
    sfr_rd_i <= 1'b1;
    @(posedge core_clk_i);
    sfr_rd_i <= 1'b0;
    @(negedge core_clk_i);
    d = sfr_rdata_o;
  endtask
  // bit 0 ends an instruction, bit 1 fires the watchdog
  task automatic pulse(input logic [1:0] m);
    @(posedge core_clk_i);
    evt <= m;
    @(posedge core_clk_i);
    evt <= 2'b00;
  endtask
  // bounded wait for halt (0) or wake detect (1) to drop
  task automatic wait_fall(input bit w, output int k);
    k = 0;
    while ((w ? wake_det : cpu_halt) !== 1'b0) begin
      @(negedge core_clk_i);
      k++;
      if (k > 2000) begin
        failures++;
        stop_test();
      end
    end
  endtask
  task automatic chk_regs();
    sfr_read(PDWC_PWRCTL_ADDR, rd);
    chk("power control", rd, exp_pwrctl[7:0]);
    sfr_read(PDWC_CKCTRL_ADDR, rd);
    chk("ckctrl", rd, exp_ck[7:0]);
    sfr_read(8'h55, rd);
    chk("unmapped", rd, 8'h00);
  endtask

  // ==========================================================
  // main sequence
  initial begin
    seed = 76348;
    rst_i = 1'b1;
    {sfr_wr_i, sfr_rd_i, irq_pending_i, rtc_wake_i} = 4'h0;
    {evt, alt_en, pull_low, ack} = 9'h000;
    sfr_addr_i = 8'h00;
    sfr_wdata_i = 8'h00;
    repeat (2) @(posedge core_clk_i);
    rst_i <= 1'b0;
    wait_fall(1'b0, cyc);
    rng("por start", cyc, 24 + 13 * SP_LO, 24 + 15 * SP_HI + 4);
    chk("rst low", 8'(cpu_rst), 8'h00);
    chk_regs();
    // random bytes, only the documented bits stick
    for (int i = 0; i < 4; i++) begin
      exp_pwrctl = $random(seed);
      exp_ck = $random(seed);
      sfr_write(PDWC_PWRCTL_ADDR, exp_pwrctl[7:0]);
      sfr_write(PDWC_CKCTRL_ADDR, exp_ck[7:0]);
      exp_pwrctl &= 8'h8F;
      exp_ck &= 8'h02;
      chk_regs();
    end
    sfr_write(PDWC_PWRCTL_ADDR, 8'h01);
    sfr_write(PDWC_CKCTRL_ADDR, 8'h00);
    exp_pwrctl = 1;
    exp_ck = 0;
    $display("test registers done");
    // idle: clock keeps running, writes refused, interrupt exits
    pulse(2'b01);
    @(negedge core_clk_i);
    chk("idle halt", 8'(cpu_halt), 8'h01);
    chk("idle clk", 8'(cpu_clk_en), 8'h01);
    sfr_write(PDWC_PWRCTL_ADDR, 8'h80);
    @(posedge core_clk_i);
    irq_pending_i <= 1'b1;
    wait_fall(1'b0, n);
    @(posedge core_clk_i);
    irq_pending_i <= 1'b0;
    exp_pwrctl = 0;
    chk_regs();
    $display("test idle done");
    // power-down and wake from each source
    for (int s = 0; s < 3; s++) begin
      sfr_write(PDWC_CKCTRL_ADDR, 8'h02);
      pulse(2'b01);
      repeat (3) @(negedge core_clk_i);
      chk("pd clocks", 8'({cpu_clk_en, sys_clk_en, reg_en}), 8'h00);
      chk("pd detect", 8'({int_det, wake_det}), 8'h01);
      @(posedge core_clk_i);
      pull_low <= 2'b11;
      irq_pending_i <= 1'b1;
      repeat (20) @(negedge core_clk_i);
      chk("pd no wake", 8'({cpu_halt, wake_det}), 8'h03);
      @(posedge core_clk_i);
      {pull_low, irq_pending_i} <= 3'b000;
      alt_en <= 2'b11;
      @(posedge core_clk_i);
      if (s == 2)
        rtc_wake_i <= 1'b1;
      else
        pull_low <= 2'(1 << s);
      irq_q.push_back(1 << s);
      wait_fall(1'b1, cyc);
      @(posedge core_clk_i);
      pull_low <= 2'b00;
      rtc_wake_i <= 1'b0;
      wait_fall(1'b0, n);
      rng("wake time", cyc + n, 52 + 2 * SP_LO, 52 + 4 * SP_HI + 4);
      chk("wake clocks", 8'({cpu_clk_en, sys_clk_en, reg_en, int_det}), 8'h0F);
      chk("wake irq", 8'(wake_irq), 8'(irq_q.pop_front()));
      exp_ck = 0;
      chk_regs();
      @(posedge core_clk_i);
      ack <= 3'(1 << s);
      alt_en <= 2'b00;
      @(posedge core_clk_i);
      ack <= 3'b000;
      @(negedge core_clk_i);
      chk("irq cleared", 8'(wake_irq), 8'h00);
    end
    $display("test power-down done");
    // stop, then power-down, each left only by the watchdog
    for (int m = 0; m < 2; m++) begin
      sfr_write(m == 0 ? PDWC_PWRCTL_ADDR : PDWC_CKCTRL_ADDR, 8'h02);
      pulse(2'b01);
      @(posedge core_clk_i);
      irq_pending_i <= 1'b1;
      repeat (20) @(negedge core_clk_i);
      chk("stay halted", 8'({cpu_halt, cpu_clk_en}), m == 0 ? 8'h03 : 8'h02);
      @(posedge core_clk_i);
      irq_pending_i <= 1'b0;
      pulse(2'b10);
      @(negedge core_clk_i);
      chk("wdog rst", 8'(cpu_rst), 8'h01);
      wait_fall(1'b0, cyc);
      rng("wdog start", cyc, 24 + 11 * SP_LO, 24 + 13 * SP_HI + 4);
      exp_pwrctl = 0;
      exp_ck = 0;
      chk_regs();
    end
    $display("test watchdog done");
    stop_test();
  end
endmodule
